// ---- ai_loop_pkg.sv ----
`default_nettype none
package ai_loop_pkg;
  // ==================================================
  // Sizes
  localparam int NCH  = 4;
  localparam int NVAR = 4;
  // ==================================================
  // Register byte offsets
  localparam logic [7:0] CFG_BASE  = 8'h00;
  localparam logic [7:0] MAP_OFS   = 8'h10;
  localparam logic [7:0] VAL_BASE  = 8'h14;
  localparam logic [7:0] STAT_OFS  = 8'h24;
  localparam logic [7:0] DIAG_BASE = 8'h28;
  localparam logic [7:0] HVAR_BASE = 8'h38;
  localparam logic [7:0] HQC_OFS   = 8'h48;
  localparam logic [7:0] ILEN_OFS  = 8'h4c;
  // ==================================================
  // Channel config and map fields
  localparam int CF_SUP  = 0;
  localparam int CF_ENC  = 1;
  localparam int CF_OVF  = 2;
  localparam int CF_UDF  = 3;
  localparam int CF_WB   = 4;
  localparam int CF_HART = 5;
  localparam int CF_MT   = 6;
  localparam int CF_SM   = 8;
  localparam int CF_WBHI = 10;
  localparam int CF_PRE  = 11;
  localparam int CF_REP  = 16;
  localparam int MP_QI   = 30;
  localparam int MP_RED  = 31;
  localparam logic [31:0] CFG_RST = 32'h0005_2880;
  localparam logic [31:0] MAP_RST = 32'h0000_0000;
  // ==================================================
  // Thresholds in microamps and codes
  localparam logic [15:0] WB_HI_SET = 16'h0e10;
  localparam logic [15:0] WB_HI_CLR = 16'h0ed8;
  localparam logic [15:0] WB_LO     = 16'h04a1;
  localparam logic [15:0] OVR_UA    = 16'h55f0;
  localparam logic [15:0] UDR_UA    = 16'h0bb8;
  localparam logic [15:0] DIS_VAL   = 16'h7fff;
  localparam logic [7:0]  PRE_BYTE  = 8'hff;
  localparam logic [4:0]  PRE_MIN   = 5'h05;
  localparam logic [4:0]  PRE_MAX   = 5'h14;
  localparam logic [7:0]  HART_CMD  = 8'h03;
  localparam logic [7:0]  QC_GOOD   = 8'h80;
  localparam logic [7:0]  QC_BAD    = 8'h00;
  localparam logic [7:0]  ILEN_AI   = 8'h08;
  localparam logic [7:0]  ILEN_QI   = 8'h01;
  localparam logic [7:0]  ILEN_VAR  = 8'h14;
  // ==================================================
  // Types
  typedef enum logic [1:0] {MT_OFF, MT_CUR, MT_HART} mtype_t;
  typedef enum logic [2:0] {VT_NONE, VT_PRI, VT_SEC, VT_TER, VT_QUA} vtype_t;
  typedef enum logic [2:0] {
    DG_NONE, DG_SUPPLY, DG_SHORT, DG_WB, DG_OVF, DG_UDF, DG_HART
  } diag_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_PRE = 3'b001, HS_CMD = 3'b011,
    HS_WAIT = 3'b010, HS_NEXT = 3'b110
  } hstate_t;
  typedef struct packed {
    logic [1:0]  ch;
    logic [15:0] ua;
    logic        supply_low;
    logic        enc_short;
  } meas_t;
  typedef struct packed {
    logic        var_valid;
    logic [1:0]  var_idx;
    logic [31:0] var_data;
    logic        done;
    logic        err;
    logic [7:0]  dev_status;
  } hrsp_t;
  // ==================================================
  // Smoothing shift: k = 1, 4, 8, 16
  function automatic logic [2:0] sm_shift(input logic [1:0] s);
    case (s)
      2'd0:    sm_shift = 3'd0;
      2'd1:    sm_shift = 3'd2;
      2'd2:    sm_shift = 3'd3;
      default: sm_shift = 3'd4;
    endcase
  endfunction
  function automatic logic [7:0] pre_cnt(input logic [4:0] p);
    if (p < PRE_MIN) pre_cnt = {3'h0, PRE_MIN};
    else if (p > PRE_MAX) pre_cnt = {3'h0, PRE_MAX};
    else pre_cnt = {3'h0, p};
  endfunction
endpackage
`default_nettype wire

// ---- ai_loop_diag.sv ----
// Summary of operation
// - Flag missing loop supply when enabled
// - Flag encoder-supply short when enabled
// - Short beats underflow when both present
// - Flag overflow above overrange when enabled
// - Flag underflow below underrange when enabled
// - Detect wire break below chosen limit
// - Wire break beats underflow
// - Below limit: value invalid; diagnostic if enabled
// - Value status cleared on wire break
// - High limit: invalid below 3.6, valid above 3.8
// - Low limit: single threshold, no hysteresis
// - Smoothing over k = 1, 4, 8, 16 cycles
// - Preamble of FF bytes before each frame
// - Resend failed request up to repeat count
// - One HART engine serves channels in turn
// - Report HART errors and device status
// - Four mapped variables: channel and type
// - Five bytes each; all four reserved if any
// - Reduced default: secondaries in channel order
// - Disabled channel returns 7FFF
// - Preamble 5..20 default 5; repeats default 5
// - Value status cleared whenever acquisition fails; a HART error (DG_HART) does not clear it
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module ai_loop_diag
  import ai_loop_pkg::*;
#(
  parameter int RSP_TO = 100000
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output var  logic        s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output var  logic        s_wready,
  output var  logic [1:0]  s_bresp,
  output var  logic        s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output var  logic        s_arready,
  output var  logic [31:0] s_rdata,
  output var  logic [1:0]  s_rresp,
  output var  logic        s_rvalid,
  input  wire logic        s_rready,
  input  wire logic        meas_valid,
  input  wire meas_t       meas,
  output var  logic [7:0]  tx_data,
  output var  logic        tx_valid,
  input  wire logic        tx_ready,
  output var  logic [1:0]  tx_ch,
  input  wire hrsp_t       rsp
);
  // ==================================================
  // Register state
  logic [31:0] cfg_ff  [NCH];
  logic [31:0] map_ff;
  logic [15:0] val_ff  [NCH];
  logic        wb_ff   [NCH];
  logic        ok_ff   [NCH];
  diag_t       diag_ff [NCH];
  logic [7:0]  hsts_ff [NCH];
  logic        herr_ff [NCH];
  logic [31:0] hv_ff   [NVAR];
  logic [7:0]  qc_ff   [NVAR];
  // ==================================================
  // Measurement path for the channel being sampled
  wire  [1:0]  mc      = meas.ch;
  wire  [31:0] mcfg    = cfg_ff[mc];
  wire         m_off   = mcfg[CF_MT+:2] == MT_OFF;
  wire         m_hi    = mcfg[CF_WBHI];
  wire         m_ovf   = meas.ua > OVR_UA;
  wire         m_udf   = meas.ua < UDR_UA;
  // Hysteresis only for the high limit; the low limit is a plain compare
  wire         m_wb    = m_hi ? (wb_ff[mc] ? (meas.ua <= WB_HI_CLR)
                                           : (meas.ua < WB_HI_SET))
                              : (meas.ua < WB_LO);
  wire [2:0]   m_sh    = sm_shift(mcfg[CF_SM+:2]);
  wire signed [16:0] m_diff = $signed({1'b0, meas.ua}) - $signed({1'b0, val_ff[mc]});
  wire signed [16:0] m_step = m_diff >>> m_sh;
  wire signed [16:0] m_sum  = $signed({1'b0, val_ff[mc]}) + m_step;
  wire [15:0]  m_val   = m_off ? DIS_VAL : m_sum[15:0];
  wire         m_hfail = mcfg[CF_HART] && (herr_ff[mc] || hsts_ff[mc] != 8'h00);
  diag_t       m_diag;
  always_comb begin
    // Earlier arms win: short and wire break both mask underflow
    if (m_off) m_diag = DG_NONE;
    else if (mcfg[CF_SUP] && meas.supply_low) m_diag = DG_SUPPLY;
    else if (mcfg[CF_ENC] && meas.enc_short) m_diag = DG_SHORT;
    else if (mcfg[CF_WB] && m_wb) m_diag = DG_WB;
    else if (mcfg[CF_OVF] && m_ovf) m_diag = DG_OVF;
    else if (mcfg[CF_UDF] && m_udf) m_diag = DG_UDF;
    else if (m_hfail) m_diag = DG_HART;
    else m_diag = DG_NONE;
  end
  // Status is independent of the diagnostic enables
  wire m_ok = !m_off && !m_wb && !meas.supply_low && !meas.enc_short
              && !m_ovf && !m_udf;
  // Only the sampled channel's filter moves; config is read live
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        val_ff[i]  <= DIS_VAL;
        wb_ff[i]   <= 1'b0;
        ok_ff[i]   <= 1'b0;
        diag_ff[i] <= DG_NONE;
      end
    end else if (meas_valid) begin
      val_ff[mc]  <= m_val;
      wb_ff[mc]   <= m_wb && !m_off;
      ok_ff[mc]   <= m_ok;
      diag_ff[mc] <= m_diag;
    end
  end
  // ==================================================
  // HART engine, one channel at a time
  hstate_t     hst_ff;
  logic [1:0]  hch_ff;
  logic [7:0]  cnt_ff;
  logic [7:0]  try_ff;
  logic [$clog2(RSP_TO+1)-1:0] to_ff;
  wire  [31:0] hcfg    = cfg_ff[hch_ff];
  wire         h_en    = hcfg[CF_MT+:2] == MT_HART;
  wire  [7:0]  h_pre   = pre_cnt(hcfg[CF_PRE+:5]);
  wire  [7:0]  h_rep   = hcfg[CF_REP+:8];
  wire         h_acc   = tx_valid && tx_ready;
  wire         h_tout  = to_ff == ($clog2(RSP_TO+1))'(RSP_TO);
  wire         h_fail  = (hst_ff == HS_WAIT) && ((rsp.done && rsp.err) || h_tout);
  wire         h_good  = (hst_ff == HS_WAIT) && rsp.done && !rsp.err;
  wire         h_retry = h_fail && (try_ff < h_rep);
  hstate_t     nxt_hst;
  always_comb begin
    nxt_hst = hst_ff;
    unique case (hst_ff)
      HS_IDLE: nxt_hst = h_en ? HS_PRE : HS_NEXT;
      HS_PRE:  if (h_acc && cnt_ff == h_pre - 8'h01) nxt_hst = HS_CMD;
      HS_CMD:  if (h_acc) nxt_hst = HS_WAIT;
      HS_WAIT: if (h_retry) nxt_hst = HS_PRE;
               else if (h_fail || h_good) nxt_hst = HS_NEXT;
      HS_NEXT: nxt_hst = HS_IDLE;
      default: nxt_hst = HS_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hst_ff   <= HS_IDLE;
      hch_ff   <= 2'd0;
      cnt_ff   <= 8'h00;
      try_ff   <= 8'h00;
      to_ff    <= '0;
      tx_valid <= 1'b0;
      tx_data  <= PRE_BYTE;
      tx_ch    <= 2'd0;
    end else begin
      hst_ff   <= nxt_hst;
      tx_valid <= nxt_hst == HS_PRE || nxt_hst == HS_CMD;
      tx_data  <= (nxt_hst == HS_CMD) ? HART_CMD : PRE_BYTE;
      tx_ch    <= hch_ff;
      if (hst_ff == HS_PRE && h_acc) cnt_ff <= cnt_ff + 8'h01;
      else if (hst_ff != HS_PRE) cnt_ff <= 8'h00;
      to_ff    <= (hst_ff == HS_WAIT) ? to_ff + 1'b1 : '0;
      if (h_retry) try_ff <= try_ff + 8'h01;
      if (hst_ff == HS_NEXT) begin
        hch_ff <= hch_ff + 2'd1;
        try_ff <= 8'h00;
      end
    end
  end
  // ==================================================
  // HART results and variable mapping
  function automatic logic [1:0] slot_ch(input int j);
    slot_ch = map_ff[MP_RED] ? 2'(j) : map_ff[8*j+:2];
  endfunction
  function automatic logic [2:0] slot_ty(input int j);
    slot_ty = map_ff[MP_RED] ? VT_SEC : map_ff[8*j+2+:3];
  endfunction
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        hsts_ff[i] <= 8'h00;
        herr_ff[i] <= 1'b0;
      end
      for (int j = 0; j < NVAR; j++) begin
        hv_ff[j] <= 32'h0000_0000;
        qc_ff[j] <= QC_BAD;
      end
    end else begin
      if (h_good) begin
        hsts_ff[hch_ff] <= rsp.dev_status;
        herr_ff[hch_ff] <= 1'b0;
      end else if (h_fail && !h_retry) begin
        herr_ff[hch_ff] <= 1'b1;
      end
      for (int j = 0; j < NVAR; j++) begin
        if (slot_ch(j) == hch_ff && slot_ty(j) != VT_NONE) begin
          if (hst_ff == HS_WAIT && rsp.var_valid
              && slot_ty(j) == {1'b0, rsp.var_idx} + 3'd1)
            hv_ff[j] <= rsp.var_data;
          if (h_good) qc_ff[j] <= QC_GOOD;
          else if (h_fail && !h_retry) qc_ff[j] <= QC_BAD;
        end
      end
    end
  end
  // Image is 8 bytes of values, one status byte if MP_QI is set, and 20 bytes if any slot maps
  logic any_map;
  always_comb begin
    any_map = map_ff[MP_RED];
    for (int j = 0; j < NVAR; j++)
      if (map_ff[8*j+2+:3] != VT_NONE) any_map = 1'b1;
  end
  wire [7:0] ilen = ILEN_AI + (map_ff[MP_QI] ? ILEN_QI : 8'h00)
                    + (any_map ? ILEN_VAR : 8'h00);
  // ==================================================
  // AXI4-Lite slave
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [7:0]  awa_ff;
  logic [31:0] wd_ff;
  logic [3:0]  ws_ff;
  wire  [5:0]  wi     = awa_ff[7:2];
  wire         w_cfg  = wi < 6'd4;
  wire         w_map  = wi == MAP_OFS[7:2];
  wire         w_do   = aw_got_ff && w_got_ff && !s_bvalid;
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    for (int b = 0; b < 4; b++)
      merge[8*b+:8] = s[b] ? n[8*b+:8] : o[8*b+:8];
  endfunction
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awa_ff    <= 8'h00;
      wd_ff     <= 32'h0000_0000;
      ws_ff     <= 4'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'b00;
      map_ff    <= MAP_RST;
      for (int i = 0; i < NCH; i++) cfg_ff[i] <= CFG_RST;
    end else begin
      s_awready <= s_awvalid && !s_awready && !aw_got_ff;
      s_wready  <= s_wvalid && !s_wready && !w_got_ff;
      if (s_awvalid && s_awready) begin
        aw_got_ff <= 1'b1;
        awa_ff    <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_got_ff <= 1'b1;
        wd_ff    <= s_wdata;
        ws_ff    <= s_wstrb;
      end
      if (w_do) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (w_cfg || w_map) ? 2'b00 : 2'b10;
        if (w_cfg) cfg_ff[wi[1:0]] <= merge(cfg_ff[wi[1:0]], wd_ff, ws_ff);
        if (w_map) map_ff <= merge(map_ff, wd_ff, ws_ff);
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  // Read decode
  wire [5:0] ri = s_araddr[7:2];
  logic [31:0] rd;
  logic        rd_ok;
  always_comb begin
    rd    = 32'h0000_0000;
    rd_ok = 1'b1;
    if (ri < 6'd4) rd = cfg_ff[ri[1:0]];
    else if (ri == MAP_OFS[7:2]) rd = map_ff;
    else if (ri >= VAL_BASE[7:2] && ri < STAT_OFS[7:2])
      rd = {16'h0000, val_ff[2'(ri - VAL_BASE[7:2])]};
    else if (ri == STAT_OFS[7:2]) begin
      for (int i = 0; i < NCH; i++) begin
        rd[i]   = ok_ff[i];
        rd[4+i] = herr_ff[i];
      end
    end else if (ri >= DIAG_BASE[7:2] && ri < HVAR_BASE[7:2])
      rd = {16'h0000, hsts_ff[2'(ri - DIAG_BASE[7:2])],
            5'h00, diag_ff[2'(ri - DIAG_BASE[7:2])]};
    else if (ri >= HVAR_BASE[7:2] && ri < HQC_OFS[7:2])
      rd = hv_ff[2'(ri - HVAR_BASE[7:2])];
    else if (ri == HQC_OFS[7:2]) rd = {qc_ff[3], qc_ff[2], qc_ff[1], qc_ff[0]};
    else if (ri == ILEN_OFS[7:2]) rd = {24'h000000, ilen};
    else rd_ok = 1'b0;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= 2'b00;
    end else begin
      s_arready <= s_arvalid && !s_arready && !s_rvalid;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd;
        s_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- ai_loop_diag_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Handshake and frame checks
module ai_loop_diag_assertions
  import ai_loop_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [1:0]  tx_ch
);
  logic [7:0] pre_n_ff;
  // Counts preamble bytes accepted since the last command byte
  always_ff @(posedge clk) begin
    if (!nrst) pre_n_ff <= 8'h00;
    else if (tx_valid && tx_ready) pre_n_ff <= (tx_data == PRE_BYTE) ? pre_n_ff + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_cmd;
    tx_valid && tx_ready && tx_data != PRE_BYTE;
  endsequence
  sequence s_rd_ans;
    s_arready ##1 s_rvalid;
  endsequence
  sequence s_tx_wait;
    tx_valid && !tx_ready;
  endsequence
  a_pre_count: assert property (s_cmd |-> pre_n_ff >= 8'h05 && pre_n_ff <= 8'h14)
    else $error("preamble length out of range");
  a_cmd_value: assert property (s_cmd |-> tx_data == HART_CMD)
    else $error("frame byte after preamble is wrong");
  a_frame_start: assert property ($rose(tx_valid) |-> tx_data == PRE_BYTE)
    else $error("frame does not open with preamble");
  a_tx_hold: assert property (s_tx_wait |=> tx_valid && $stable({tx_data, tx_ch}))
    else $error("modem byte changed before accept");
  a_tx_drop: assert property (s_cmd |=> !tx_valid)
    else $error("modem valid stays after command");
  a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  a_rd_answer: assert property ($rose(s_arvalid) |=> s_rd_ans)
    else $error("read answer late");
endmodule
bind ai_loop_diag ai_loop_diag_assertions u_ai_loop_diag_assertions (.*);
`default_nettype wire

// ---- hart_field_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Field transmitters behind the modem
module hart_field_model
  import ai_loop_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic [1:0] tx_ch,
  input  wire logic [3:0] bad,
  output var  logic       tx_ready,
  output var  hrsp_t      rsp
);
  logic [7:0] npre_ff;
  logic [7:0] pre[4];
  int         fr[4];
  logic       run_ff;
  logic [2:0] k_ff;
  logic       slow_ff;
  // Modem takes a byte every other cycle, so the engine must hold
  assign tx_ready = slow_ff;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      slow_ff <= 1'b0;
      npre_ff <= 8'h00;
      run_ff <= 1'b0;
      k_ff <= 3'h0;
      rsp <= '0;
      fr <= '{default: 0};
      pre <= '{default: 8'h00};
    end else begin
      slow_ff <= ~slow_ff;
      rsp.var_valid <= 1'b0;
      rsp.done <= 1'b0;
      // Data lines toggle outside a reply so stale values never match
      rsp.var_data <= ~rsp.var_data;
      if (tx_valid && tx_ready) begin
        if (tx_data == 8'hff) npre_ff <= npre_ff + 8'h01;
        else begin
          pre[tx_ch] <= npre_ff;
          fr[tx_ch] <= fr[tx_ch] + 1;
          npre_ff <= 8'h00;
          run_ff <= 1'b1;
          k_ff <= 3'h0;
        end
      end
      if (run_ff) begin
        k_ff <= k_ff + 3'h1;
        if (k_ff < 3'h4 && !bad[tx_ch]) begin
          rsp.var_valid <= 1'b1;
          rsp.var_idx <= k_ff[1:0];
          rsp.var_data <= {16'h5ec0, 6'h00, tx_ch, 6'h00, k_ff[1:0]};
        end
        if (k_ff == 3'h4) begin
          rsp.done <= 1'b1;
          rsp.err <= bad[tx_ch];
          // Status byte names the channel so a stale or misrouted byte shows
          rsp.dev_status <= {6'h00, tx_ch};
          run_ff <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- loop_current_input_diag_hart_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench top
module loop_current_input_diag_hart_tb_top
  import ai_loop_pkg::*;
;
  logic        clk, nrst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, meas_valid, tx_valid, tx_ready;
  logic [7:0]  s_awaddr, s_araddr, tx_data;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb, bad;
  logic [1:0]  s_bresp, s_rresp, tx_ch;
  meas_t       meas;
  hrsp_t       rsp;
  int          fail_count, n_tests;
  ai_loop_diag #(.RSP_TO(50)) u_ai_loop_diag (.*);
  hart_field_model u_hart_field_model (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    fail_count++;
    $display("unexpected at %0t: wait ran out", $time);
    finish_test();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    if (i == 50) tmo();
    r = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    if (i == 50) tmo();
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, 32'h0);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d & m, e);
  endtask
  task automatic send(input logic [1:0] c, input logic [15:0] u, input logic sp, input logic en);
    @(posedge clk);
    meas <= '{c, u, sp, en};
    meas_valid <= 1'b1;
    @(posedge clk);
    meas_valid <= 1'b0;
  endtask
  // Channel 1 sample, then its diagnostic code and value status
  task automatic dc(input logic [15:0] u, input logic sp, input logic en, input int c, input int s);
    send(2'd1, u, sp, en);
    rc(DIAG_BASE + 8'h04, 32'h7, c);
    rc(STAT_OFS, 32'h2, s);
  endtask
  task automatic wfr(input int c, input int n);
    int i, b;
    b = u_hart_field_model.fr[c];
    for (i = 0; i < 4000; i++) begin
      @(posedge clk);
      if (u_hart_field_model.fr[c] >= b + n) break;
    end
    if (i == 4000) tmo();
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rc(CFG_BASE, 32'hffffffff, CFG_RST);
    rc(MAP_OFS, 32'hffffffff, MAP_RST);
    rc(VAL_BASE, 32'hffff, {16'h0, DIS_VAL});
    rc(ILEN_OFS, 32'hff, {24'h0, ILEN_AI});
    rd(8'h80, d, r);
    chk({30'h0, r}, 32'h2);
    wr(VAL_BASE, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    $display("test reset done");
  endtask
  task automatic t_diag();
    w(CFG_BASE + 8'h04, 32'h0005_285f);
    w(MAP_OFS, 32'h4000_0000);
    rc(ILEN_OFS, 32'hff, 32'h9);
    dc(16'd500, 0, 0, 3, 0);
    dc(16'd2000, 0, 1, 2, 0);
    dc(16'd10000, 1, 0, 1, 0);
    dc(16'd23000, 0, 0, 4, 0);
    dc(16'd2500, 0, 0, 5, 0);
    dc(16'd10000, 0, 0, 0, 2);
    w(CFG_BASE + 8'h04, 32'h0005_2840);
    dc(16'd500, 0, 0, 0, 0);
    w(CFG_BASE + 8'h04, 32'h0005_2c50);
    dc(16'd10000, 0, 0, 0, 2);
    dc(16'd3700, 0, 0, 0, 2);
    dc(16'd3500, 0, 0, 3, 0);
    dc(16'd3700, 0, 0, 3, 0);
    dc(16'd3900, 0, 0, 0, 2);
    w(CFG_BASE + 8'h04, 32'h0005_2850);
    dc(16'd1184, 0, 0, 3, 0);
    dc(16'd1186, 0, 0, 0, 0);
    $display("test diag done");
  endtask
  task automatic t_smooth();
    w(CFG_BASE + 8'h04, 32'h0005_2840);
    w(CFG_BASE + 8'h08, 32'h0005_2800);
    rc(VAL_BASE + 8'h04, 32'hffff, 32'd1186);
    send(2'd1, 16'd8000, 0, 0);
    rc(VAL_BASE + 8'h04, 32'hffff, 32'd8000);
    w(CFG_BASE + 8'h04, 32'h0005_2940);
    send(2'd1, 16'd16000, 0, 0);
    rc(VAL_BASE + 8'h04, 32'hffff, 32'd10000);
    send(2'd1, 16'd16000, 0, 0);
    rc(VAL_BASE + 8'h04, 32'hffff, 32'd11500);
    w(CFG_BASE + 8'h04, 32'h0005_2b40);
    send(2'd1, 16'd16000, 0, 0);
    rc(VAL_BASE + 8'h04, 32'hffff, 32'd11781);
    w(CFG_BASE + 8'h04, 32'h0005_2a40);
    send(2'd1, 16'd16000, 0, 0);
    rc(VAL_BASE + 8'h04, 32'hffff, 32'd12308);
    send(2'd2, 16'd9000, 0, 0);
    rc(VAL_BASE + 8'h08, 32'hffff, {16'h0, DIS_VAL});
    $display("test smooth done");
  endtask
  task automatic t_hart();
    logic [4:0] pv[3] = '{5'd3, 5'd20, 5'd25};
    int         ev[3] = '{5, 20, 20};
    w(CFG_BASE + 8'h04, CFG_RST);
    w(CFG_BASE + 8'h08, CFG_RST);
    for (int i = 0; i < 3; i++) begin
      w(CFG_BASE, {8'h00, 8'h05, pv[i], 3'b000, 8'h80});
      wfr(0, 2);
      chk({24'h0, u_hart_field_model.pre[0]}, ev[i]);
    end
    w(MAP_OFS, 32'h0000_1108);
    wfr(0, 2);
    rc(HVAR_BASE, 32'hffffffff, 32'h5ec0_0001);
    rc(HVAR_BASE + 8'h04, 32'hffffffff, 32'h5ec0_0103);
    rc(HQC_OFS, 32'hff, {24'h0, QC_GOOD});
    rc(ILEN_OFS, 32'hff, 32'h1c);
    w(MAP_OFS, 32'h8000_0000);
    wfr(3, 2);
    for (int j = 0; j < 4; j++) begin
      rc(HVAR_BASE + 8'(4 * j), 32'hffffffff, {16'h5ec0, 6'h0, 2'(j), 8'h01});
    end
    rc(DIAG_BASE + 8'h0c, 32'hff00, 32'h0300);
    $display("test hart done");
  endtask
  task automatic t_retry();
    int a;
    w(CFG_BASE, 32'h0002_28a0);
    bad <= 4'h1;
    wfr(1, 1);
    a = u_hart_field_model.fr[0];
    wfr(1, 1);
    chk(u_hart_field_model.fr[0] - a, 32'd3);
    rc(STAT_OFS, 32'h10, 32'h10);
    // The diagnostic code only moves with a sample of that channel
    send(2'd0, 16'd10000, 0, 0);
    rc(DIAG_BASE, 32'h7, 32'h6);
    rc(HQC_OFS, 32'hff, {24'h0, QC_BAD});
    $display("test retry done");
  endtask
  initial begin
    nrst = 1'b0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, meas_valid} = '0;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0;
    s_wstrb = 4'hf;
    bad = 4'h0;
    meas = '0;
    fail_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_diag();
    t_smooth();
    t_hart();
    t_retry();
    finish_test();
  end
endmodule
`default_nettype wire
